//--- logic/fmx_core.sv
// Execution core for OR-into-file, copy-file, pointer-load and file-to-file move
//
// What this block does
// - OR writes accumulator OR file byte to the d destination and sets negative and zero.
// - File bytes use the access bank when a is 0 and the bank select page when a is 1.
// - Extended set on, a at 0 and offset up to 95: OR and copy use indexed literal offset.
// - Pointer-load puts a 12-bit literal into pointer 0, 1 or 2 and leaves all flags alone.
// - Pointer-load takes two words, the second prefixed 1111 0000, and two cycles.
// - Copy puts a file byte in the accumulator or the file by d and sets negative and zero.
// - Copy and OR take any 8-bit offset and finish in one instruction cycle of one word.
// - The move uses full 12-bit source and destination addresses, ignoring the bank select.
// - The move takes a 1100 word then a 1111 word, copies in two cycles and keeps the flags.
// - The move may use the accumulator location as source or destination.
module fmx_core import fmx_pkg::*; (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    output logic             instr_ready,
    output logic      [11:0] dmem_addr,
    output logic             dmem_rd,
    output logic             dmem_wr,
    output logic      [7:0]  dmem_wdata,
    input  wire logic [7:0]  dmem_rdata
);

    typedef struct packed {
        fmx_state_t       st;
        logic [1:0]       q;
        fmx_op_t          op;
        logic [15:0]      ir;
        logic [15:0]      ir2;
        logic [11:0]      addr;
        logic [7:0]       data;
        logic             res_n;
        logic             res_z;
        logic [7:0]       accum;
        logic             flag_n;
        logic             flag_z;
        logic [3:0]       bank;
        logic [2:0][11:0] ptr;
        logic             ext_en;
        logic             bad2;
        logic             ill_dst;
        logic             instr_ready;
        logic [11:0]      dmem_addr;
        logic             dmem_rd;
        logic             dmem_wr;
        logic [7:0]       dmem_wdata;
        logic             pready;
        logic [31:0]      prdata;
        logic             pslverr;
    } fmx_rec_t;

    localparam fmx_rec_t REC_RST = '{st: ST_FETCH, q: PH_Q1, op: OP_NONE,
                                     accum: RST_ACCUM, bank: RST_BANK, default: '0};

    fmx_rec_t    s;
    fmx_rec_t    next_s;
    logic [11:0] file_addr;
    logic [7:0]  rd_val;
    logic [7:0]  alu_res;
    logic        alu_n;
    logic        alu_z;
    logic        take;
    logic        apb_wr;
    fmx_op_t     dec_op;

    assign prdata      = s.prdata;
    assign pready      = s.pready;
    assign pslverr     = s.pslverr;
    assign instr_ready = s.instr_ready;
    assign dmem_addr   = s.dmem_addr;
    assign dmem_rd     = s.dmem_rd;
    assign dmem_wr     = s.dmem_wr;
    assign dmem_wdata  = s.dmem_wdata;

    fmx_addr_former u_addr (
        .file_off        (s.ir[7:0]),
        .bank_bit        (s.ir[BIT_A]),
        .bank_select_reg (s.bank),
        .ext_en          (s.ext_en),
        .index_ptr       (s.ptr[INDEXED_PTR]),
        .data_addr       (file_addr)
    );

    fmx_alu u_alu (
        .do_or    (s.op == OP_OR),
        .accum    (s.accum),
        .file_val (rd_val),
        .result   (alu_res),
        .neg      (alu_n),
        .zero     (alu_z)
    );

    function automatic fmx_op_t decode_op(input logic [15:0] w);
        if (w[15:10] == OPC_OR) begin
            decode_op = OP_OR;
        end else if (w[15:10] == OPC_COPY) begin
            decode_op = OP_COPY;
        end else if (w[15:6] == OPC_PTR) begin
            decode_op = OP_PTR;
        end else if (w[15:12] == OPC_MOVE) begin
            decode_op = OP_MOVE;
        end else begin
            decode_op = OP_NONE;
        end
    endfunction

    function automatic logic is_forbidden(input logic [11:0] a);
        is_forbidden = (a == PC_LOW_ADDR) || (a == STACK_UP_ADDR) ||
                       (a == STACK_HI_ADDR) || (a == STACK_LO_ADDR);
    endfunction

    // Reads of the accumulator's location never go out on the data bus
    assign rd_val = (s.addr == ACCUM_ADDR) ? s.accum : dmem_rdata;
    assign take   = (s.q == PH_Q1) && s.instr_ready && instr_valid;
    assign apb_wr = psel && penable && s.pready && pwrite;
    assign dec_op = decode_op(instr_word);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s            = s;
        next_s.q          = s.q + 2'h1;
        next_s.dmem_rd    = 1'b0;
        next_s.dmem_wr    = 1'b0;
        next_s.pslverr    = 1'b0;
        // One wait state: the answer comes in the second access cycle
        next_s.pready     = psel && penable && !s.pready;

        // APB first so that core updates in the same cycle win
        if (next_s.pready) begin
            next_s.prdata = '0;
            if (paddr == OFS_CTRL) begin
                next_s.prdata[CTRL_EXT_BIT] = s.ext_en;
            end else if (paddr == OFS_ACCUM) begin
                next_s.prdata[7:0] = s.accum;
            end else if (paddr == OFS_FLAGS) begin
                next_s.prdata[FLAG_Z_BIT] = s.flag_z;
                next_s.prdata[FLAG_N_BIT] = s.flag_n;
            end else if (paddr == OFS_BANK) begin
                next_s.prdata[3:0] = s.bank;
            end else if (paddr == OFS_STATUS) begin
                next_s.prdata[STAT_BUSY_BIT] = (s.st != ST_FETCH);
                next_s.prdata[STAT_BAD2_BIT] = s.bad2;
                next_s.prdata[STAT_ILL_BIT]  = s.ill_dst;
            end else begin
                next_s.pslverr = 1'b1;
                for (int i = 0; i < PTR_COUNT; i++) begin
                    if (paddr == OFS_PTR0 + OFS_PTR_STRIDE * 12'(i)) begin
                        next_s.prdata[11:0] = s.ptr[i];
                        next_s.pslverr      = 1'b0;
                    end
                end
            end
        end
        if (apb_wr) begin
            if (paddr == OFS_CTRL) begin
                next_s.ext_en = pwdata[CTRL_EXT_BIT];
            end else if (paddr == OFS_ACCUM) begin
                next_s.accum = pwdata[7:0];
            end else if (paddr == OFS_FLAGS) begin
                next_s.flag_z = pwdata[FLAG_Z_BIT];
                next_s.flag_n = pwdata[FLAG_N_BIT];
            end else if (paddr == OFS_BANK) begin
                next_s.bank = pwdata[3:0];
            end else if (paddr == OFS_STATUS) begin
                // Write one to clear; a fault in the same cycle sets it again below
                if (pwdata[STAT_BAD2_BIT]) begin
                    next_s.bad2 = 1'b0;
                end
                if (pwdata[STAT_ILL_BIT]) begin
                    next_s.ill_dst = 1'b0;
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////
        case (s.st)
            ST_FETCH: begin
                if (take) begin
                    next_s.ir = instr_word;
                    next_s.op = dec_op;
                    next_s.st = ST_EXEC1;
                end
            end
            ST_EXEC1: begin
                case (s.q)
                    PH_Q2: begin
                        if (s.op == OP_OR || s.op == OP_COPY) begin
                            next_s.addr      = file_addr;
                            next_s.dmem_addr = file_addr;
                            next_s.dmem_rd   = (file_addr != ACCUM_ADDR);
                        end else if (s.op == OP_MOVE) begin
                            next_s.addr      = s.ir[11:0];
                            next_s.dmem_addr = s.ir[11:0];
                            next_s.dmem_rd   = (s.ir[11:0] != ACCUM_ADDR);
                        end
                    end
                    PH_Q3: begin
                        if (s.op == OP_OR || s.op == OP_COPY) begin
                            next_s.data  = alu_res;
                            next_s.res_n = alu_n;
                            next_s.res_z = alu_z;
                            if (s.ir[BIT_D] && (s.addr != ACCUM_ADDR)) begin
                                next_s.dmem_wr    = 1'b1;
                                next_s.dmem_addr  = s.addr;
                                next_s.dmem_wdata = alu_res;
                            end
                        end else if (s.op == OP_MOVE) begin
                            next_s.data = rd_val;
                        end
                    end
                    PH_Q4: begin
                        if (s.op == OP_OR || s.op == OP_COPY) begin
                            if (!s.ir[BIT_D] || (s.addr == ACCUM_ADDR)) begin
                                next_s.accum = s.data;
                            end
                            next_s.flag_n = s.res_n;
                            next_s.flag_z = s.res_z;
                        end else if (s.op == OP_PTR && s.ir[5:4] != PTR_SEL_BAD) begin
                            next_s.ptr[s.ir[5:4]][11:8] = s.ir[3:0];
                        end
                        if (s.op == OP_PTR || s.op == OP_MOVE) begin
                            next_s.st = ST_WORD2;
                        end else begin
                            next_s.st = ST_FETCH;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            ST_WORD2: begin
                if (take) begin
                    // second word must start 1111, and 1111 0000 for pointer-load
                    if (instr_word[15:12] == OPC_SECOND &&
                        (s.op == OP_MOVE || instr_word[11:8] == OPC_PTR2_ZERO)) begin
                        next_s.ir2 = instr_word;
                        next_s.st  = ST_EXEC2;
                    end else begin
                        // A malformed second word is dropped and not executed
                        next_s.bad2 = 1'b1;
                        next_s.st   = ST_FETCH;
                    end
                end
            end
            ST_EXEC2: begin
                case (s.q)
                    PH_Q3: begin
                        // no bus read, write in last phase
                        if (s.op == OP_MOVE) begin
                            if (is_forbidden(s.ir2[11:0])) begin
                                next_s.ill_dst = 1'b1;
                            end else if (s.ir2[11:0] != ACCUM_ADDR) begin
                                next_s.dmem_wr    = 1'b1;
                                next_s.dmem_addr  = s.ir2[11:0];
                                next_s.dmem_wdata = s.data;
                            end
                        end
                    end
                    PH_Q4: begin
                        if (s.op == OP_MOVE && s.ir2[11:0] == ACCUM_ADDR) begin
                            next_s.accum = s.data;
                        end else if (s.op == OP_PTR && s.ir[5:4] != PTR_SEL_BAD) begin
                            next_s.ptr[s.ir[5:4]][7:0] = s.ir2[7:0];
                        end
                        next_s.st = ST_FETCH;
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                next_s.st = ST_FETCH;
            end
        endcase

        next_s.instr_ready = (next_s.q == PH_Q1) &&
                             (next_s.st == ST_FETCH || next_s.st == ST_WORD2);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= REC_RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_or_accum;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_EXEC1 && s.op == OP_OR && s.q == PH_Q3 && !s.ir[BIT_D])
            |-> ##2 (s.accum == $past(s.accum | rd_val, 2));
    endproperty
    a_or_accum: assert property (p_or_accum) else $error("OR result missing");

    property p_bank_addr;
        @(posedge pclk) disable iff (!presetn)
        s.ir[BIT_A] |-> (file_addr == {s.bank, s.ir[7:0]});
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong");

    property p_indexed;
        @(posedge pclk) disable iff (!presetn)
        (s.ext_en && !s.ir[BIT_A] && s.ir[7:0] < ACCESS_SPLIT)
            |-> (file_addr == s.ptr[INDEXED_PTR] + {4'h0, s.ir[7:0]});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_ptr_flags;
        @(posedge pclk) disable iff (!presetn)
        ((s.st == ST_EXEC1 || s.st == ST_EXEC2) && s.op != OP_OR && s.op != OP_COPY &&
         !apb_wr) |=> ($stable(s.flag_n) && $stable(s.flag_z));
    endproperty
    a_ptr_flags: assert property (p_ptr_flags) else $error("flags changed");

    property p_ptr_low;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_EXEC2 && s.op == OP_PTR && s.q == PH_Q4 && s.ir[5:4] != PTR_SEL_BAD)
            |=> (s.ptr[$past(s.ir[5:4])][7:0] == $past(s.ir2[7:0]));
    endproperty
    a_ptr_low: assert property (p_ptr_low) else $error("pointer low byte wrong");

    property p_copy_back;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_EXEC1 && s.op == OP_COPY && s.q == PH_Q3 && s.ir[BIT_D] &&
         s.addr != ACCUM_ADDR)
            |=> (s.dmem_wr && s.dmem_wdata == $past(rd_val) && s.dmem_addr == $past(s.addr));
    endproperty
    a_copy_back: assert property (p_copy_back) else $error("copy write-back wrong");

    property p_single_cycle;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_FETCH && take && (dec_op == OP_OR || dec_op == OP_COPY))
            |-> ##4 (s.st == ST_FETCH && s.instr_ready);
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("not one cycle");

    property p_move_src;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_EXEC1 && s.op == OP_MOVE && s.q == PH_Q2)
            |=> (s.dmem_addr == $past(s.ir[11:0]) &&
                 s.dmem_rd == ($past(s.ir[11:0]) != ACCUM_ADDR));
    endproperty
    a_move_src: assert property (p_move_src) else $error("move source wrong");

    property p_move_write;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_WORD2 && take && s.op == OP_MOVE && instr_word[15:12] == OPC_SECOND &&
         instr_word[11:0] != ACCUM_ADDR && !is_forbidden(instr_word[11:0]))
            |-> ##3 (s.dmem_wr && s.dmem_addr == $past(instr_word[11:0], 3) &&
                     s.dmem_wdata == s.data);
    endproperty
    a_move_write: assert property (p_move_write) else $error("move write wrong");

    property p_move_accum;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_EXEC2 && s.op == OP_MOVE && s.q == PH_Q4 && s.ir2[11:0] == ACCUM_ADDR)
            |=> (s.accum == $past(s.data));
    endproperty
    a_move_accum: assert property (p_move_accum) else $error("move to accum wrong");

    property p_ptr_high;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_EXEC1 && s.op == OP_PTR && s.q == PH_Q4 && s.ir[5:4] != PTR_SEL_BAD)
            |=> (s.ptr[$past(s.ir[5:4])][11:8] == $past(s.ir[3:0]));
    endproperty
    a_ptr_high: assert property (p_ptr_high) else $error("pointer high byte wrong");

    property p_move_no_read;
        @(posedge pclk) disable iff (!presetn)
        (s.st == ST_EXEC2) |-> !s.dmem_rd;
    endproperty
    a_move_no_read: assert property (p_move_no_read) else $error("read in cycle two");

endmodule

//--- logic/fmx_pkg.sv
// Shared constants and types for the file move / pointer load execution block
package fmx_pkg;

    // Four phases of one instruction cycle, one pclk each
    localparam logic [1:0]  PH_Q1          = 2'h0;
    localparam logic [1:0]  PH_Q2          = 2'h1;
    localparam logic [1:0]  PH_Q3          = 2'h2;
    localparam logic [1:0]  PH_Q4          = 2'h3;

    // APB register byte offsets
    localparam logic [11:0] OFS_CTRL       = 12'h000;
    localparam logic [11:0] OFS_ACCUM      = 12'h004;
    localparam logic [11:0] OFS_FLAGS      = 12'h008;
    localparam logic [11:0] OFS_BANK       = 12'h00C;
    localparam logic [11:0] OFS_PTR0       = 12'h010;
    localparam logic [11:0] OFS_PTR_STRIDE = 12'h004;
    localparam logic [11:0] OFS_STATUS     = 12'h01C;

    // Register field positions
    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          FLAG_Z_BIT     = 0;
    localparam int          FLAG_N_BIT     = 1;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_BAD2_BIT  = 1;
    localparam int          STAT_ILL_BIT   = 2;

    // Opcode fields
    localparam logic [5:0]  OPC_OR         = 6'h04;
    localparam logic [5:0]  OPC_COPY       = 6'h14;
    localparam logic [9:0]  OPC_PTR        = 10'h3B8;
    localparam logic [3:0]  OPC_MOVE       = 4'hC;
    localparam logic [3:0]  OPC_SECOND     = 4'hF;
    localparam logic [3:0]  OPC_PTR2_ZERO  = 4'h0;
    localparam int          BIT_D          = 9;
    localparam int          BIT_A          = 8;

    // Access bank split and indexed addressing
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
    localparam int          INDEXED_PTR    = 2;
    localparam int          PTR_COUNT      = 3;
    localparam logic [1:0]  PTR_SEL_BAD    = 2'h3;

    // Data space locations of core registers
    localparam logic [11:0] ACCUM_ADDR     = 12'hFE0;
    localparam logic [11:0] PC_LOW_ADDR    = 12'hFF0;
    localparam logic [11:0] STACK_UP_ADDR  = 12'hFF1;
    localparam logic [11:0] STACK_HI_ADDR  = 12'hFF2;
    localparam logic [11:0] STACK_LO_ADDR  = 12'hFF3;

    // Reset values
    localparam logic [7:0]  RST_ACCUM      = 8'h00;
    localparam logic [3:0]  RST_BANK       = 4'h0;

    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_EXEC1 = 2'b01,
        ST_WORD2 = 2'b10,
        ST_EXEC2 = 2'b11
    } fmx_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_OR   = 3'b001,
        OP_COPY = 3'b010,
        OP_PTR  = 3'b011,
        OP_MOVE = 3'b100
    } fmx_op_t;

endpackage

//--- logic/fmx_addr_former.sv
// Forms the 12-bit data address of a byte-oriented file instruction
module fmx_addr_former import fmx_pkg::*; (
    input  wire logic [7:0]  file_off,
    input  wire logic        bank_bit,
    input  wire logic [3:0]  bank_select_reg,
    input  wire logic        ext_en,
    input  wire logic [11:0] index_ptr,
    output logic      [11:0] data_addr
);

    always_comb begin
        if (bank_bit) begin
            data_addr = {bank_select_reg, file_off};
        end else if (ext_en && (file_off < ACCESS_SPLIT)) begin
            // Indexed literal offset: pointer plus offset, wraps in the data space
            data_addr = index_ptr + {4'h0, file_off};
        end else if (file_off < ACCESS_SPLIT) begin
            data_addr = {ACCESS_LO_BANK, file_off};
        end else begin
            data_addr = {ACCESS_HI_BANK, file_off};
        end
    end

endmodule

//--- logic/fmx_alu.sv
// OR / pass-through unit with negative and zero results
module fmx_alu import fmx_pkg::*; (
    input  wire logic       do_or,
    input  wire logic [7:0] accum,
    input  wire logic [7:0] file_val,
    output logic      [7:0] result,
    output logic            neg,
    output logic            zero
);

    always_comb begin
        result = do_or ? (accum | file_val) : file_val;
        neg    = result[7];
        zero   = (result == 8'h00);
    end

endmodule

//--- bench/fmx_dmem_model.sv
// Data space model with a combinational read port
module fmx_dmem_model (
    input  wire logic        pclk,
    input  wire logic [11:0] dmem_addr,
    input  wire logic        dmem_rd,
    input  wire logic        dmem_wr,
    input  wire logic [7:0]  dmem_wdata,
    output logic      [7:0]  dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    logic [7:0] last = 8'h00;
    // Idle bus shows a flipped byte so a stale value never looks valid
    assign dmem_rdata = dmem_rd ? mem[dmem_addr] : ~last;
    always @(posedge pclk) begin
        if (dmem_wr) begin
            mem[dmem_addr] <= dmem_wdata;
        end
        if (dmem_rd) begin
            last <= mem[dmem_addr];
        end
    end
endmodule

//--- bench/fmx_core_test.sv
// Self-checking bench for the execution core
module fmx_core_test import fmx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        instr_valid = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] instr_word = 16'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, instr_ready, dmem_rd, dmem_wr;
    logic [11:0] dmem_addr, k;
    logic [7:0]  dmem_wdata, dmem_rdata;
    logic [11:0] kv [3] = '{12'hFFF, 12'h001, 12'h3AB};
    int          num_errors = 0;
    int          samples_checked = 0;
    fmx_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .instr_word, .instr_valid, .instr_ready, .dmem_addr,
        .dmem_rd, .dmem_wr, .dmem_wdata, .dmem_rdata);
    fmx_dmem_model mem_model (.pclk, .dmem_addr, .dmem_rd, .dmem_wr, .dmem_wdata,
        .dmem_rdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Request stands until pready is seen high at a rising edge; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    // The word is taken at the rising edge where ready is seen high with valid
    task automatic issue(input logic [15:0] w, input logic v);
        @(posedge pclk);
        instr_valid <= v;
        instr_word <= w;
        do begin
            @(posedge pclk);
        end while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
    endtask
    // An empty slot lets the previous instruction finish its last phase
    task automatic settle();
        issue(16'h0000, 1'b0);
    endtask
    task automatic stop_test();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (6000) @(posedge pclk);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(12'(4 * i), 32'h0);
        rchk(12'h020, 32'h0);
        check(err, 1'b1);
        mem_model.mem[12'h020] = 8'h91;
        mem_model.mem[12'h580] = 8'h04;
        mem_model.mem[12'hF70] = 8'h00;
        mem_model.mem[12'h5FF] = 8'h7F;
        apb(1'b1, OFS_ACCUM, 32'h13);
        issue(16'h1020, 1'b1);
        settle();
        rchk(OFS_ACCUM, 32'h93);
        rchk(OFS_FLAGS, 32'h2);
        apb(1'b1, OFS_BANK, 32'h5);
        issue(16'h1380, 1'b1);
        settle();
        check(mem_model.mem[12'h580], 8'h97);
        issue(16'h5070, 1'b1);
        settle();
        rchk(OFS_ACCUM, 32'h0);
        rchk(OFS_FLAGS, 32'h1);
        issue(16'h53FF, 1'b1);
        settle();
        check(mem_model.mem[12'h5FF], 8'h7F);
        rchk(OFS_FLAGS, 32'h0);
        apb(1'b1, OFS_FLAGS, 32'h3);
        for (int p = 0; p < 3; p++) begin
            k = kv[p];
            issue({8'hEE, 2'b00, 2'(p), k[11:8]}, 1'b1);
            settle();
            rchk(OFS_PTR0 + 12'(4 * p), {20'h0, k[11:8], 8'h00});
            issue({8'hF0, k[7:0]}, 1'b1);
            settle();
            rchk(OFS_PTR0 + 12'(4 * p), {20'h0, k});
        end
        rchk(OFS_FLAGS, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h1);
        mem_model.mem[12'h3B0] = 8'h80;
        issue(16'h5005, 1'b1);
        settle();
        rchk(OFS_ACCUM, 32'h80);
        apb(1'b1, OFS_CTRL, 32'h0);
        // Flags differ from the last copy result, so a stray flag update shows
        apb(1'b1, OFS_FLAGS, 32'h1);
        mem_model.mem[12'h123] = 8'h5A;
        issue(16'hC123, 1'b1);
        issue(16'hFABC, 1'b1);
        settle();
        check(mem_model.mem[12'hABC], 8'h5A);
        rchk(OFS_FLAGS, 32'h1);
        issue(16'hC123, 1'b1);
        issue(16'hFFE0, 1'b1);
        settle();
        rchk(OFS_ACCUM, 32'h5A);
        issue(16'hCFE0, 1'b1);
        issue(16'hF777, 1'b1);
        settle();
        check(mem_model.mem[12'h777], 8'h5A);
        // Deliberate protected destination, the core must refuse it
        mem_model.mem[12'hFF0] = 8'h11;
        issue(16'hC123, 1'b1);
        issue(16'hFFF0, 1'b1);
        settle();
        check(mem_model.mem[12'hFF0], 8'h11);
        rchk(OFS_STATUS, 32'h4);
        apb(1'b1, OFS_STATUS, 32'h4);
        issue(16'hC123, 1'b1);
        issue(16'h0000, 1'b1);
        settle();
        rchk(OFS_STATUS, 32'h2);
        stop_test();
    end
endmodule
